// >>> design/dagc_map.vh
/*
 * register map, field positions, reset values and frame layout of the gain control bank.
 * assumes a 16-bit serial frame: direction, reserved, address nibble, then data byte.
 */
`ifndef DAGC_MAP_VH
`define DAGC_MAP_VH

`define DAGC_ADDR_POWER      4'h2
`define DAGC_ADDR_GAIN_A     4'h3
`define DAGC_ADDR_GAIN_B     4'h4
`define DAGC_ADDR_ROUTE      4'h5

`define DAGC_RST_POWER       8'h00
`define DAGC_RST_GAIN        8'h50
`define DAGC_RST_ROUTE       8'h03
`define DAGC_RST_CODE        7'h50

`define DAGC_POW_A_FIRST     5
`define DAGC_POW_B_FIRST     4
`define DAGC_POW_A_SECOND    3
`define DAGC_POW_B_SECOND    2
`define DAGC_ROUTE_GANG      2
`define DAGC_ROUTE_LOAD_A    1
`define DAGC_ROUTE_LOAD_B    0

`define DAGC_GAIN_MAX        7'h50
`define DAGC_FRAME_BITS      5'h10
`define DAGC_DIR_POS         15
`define DAGC_ADDR_MSB        3
`define DAGC_DATA_MSB        7
`define DAGC_ADDR_LAST_BIT   5'h07
`define DAGC_DATA_FIRST      5'h08
`define DAGC_DATA_LAST       5'h0f

`endif

// >>> design/dagc_regs.v
/*
 * serial-programmed control register bank of a dual programmable-gain amplifier.
 * assumes serial clock, select and data arrive from outside core_clk's domain and that
 * core_clk runs well above four times the serial clock rate.
 */
`timescale 1ns/1ps
`include "dagc_map.vh"

module dagc_regs (
    input  wire       core_clk,
    input  wire       sys_rst,
    input  wire       clk_en,
    input  wire       ser_clk,
    input  wire       ser_sel_n,
    input  wire       ser_din,
    output reg        ser_dout,
    output reg        ser_dout_oe_n,
    output reg  [6:0] chan_a_gain,
    output reg  [6:0] chan_b_gain,
    output reg        chan_a_off_first,
    output reg        chan_a_off_second,
    output reg        chan_b_off_first,
    output reg        chan_b_off_second,
    output reg        gain_code_error
);

    // =====================================================================
    // input synchronisers
    reg [2:0]  sclk_sync_reg;
    reg [2:0]  sel_sync_reg;
    reg [1:0]  din_sync_reg;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            sclk_sync_reg <= 3'h0;
            sel_sync_reg  <= 3'h7;
            din_sync_reg  <= 2'h0;
        end else if (clk_en) begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], ser_clk};
            sel_sync_reg  <= {sel_sync_reg[1:0], ser_sel_n};
            din_sync_reg  <= {din_sync_reg[0], ser_din};
        end
    end

    // only stages 1 and 2 feed logic; stage 0 is read by stage 1 alone
    wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    wire selected  = ~sel_sync_reg[1];
    wire sel_fall  = ~sel_sync_reg[1] & sel_sync_reg[2];
    wire sel_rise  = sel_sync_reg[1] & ~sel_sync_reg[2];

    // =====================================================================
    // registers
    reg [7:0]  power_reg;
    reg [7:0]  gain_first_reg;
    reg [7:0]  gain_second_reg;
    reg [7:0]  route_reg;
    reg [15:0] shift_reg;
    reg [4:0]  bit_cnt_reg;
    reg [7:0]  out_shift_reg;

    wire [3:0] frame_addr = shift_reg[`DAGC_ADDR_MSB + 8:8];
    wire       frame_read = shift_reg[`DAGC_DIR_POS];
    wire [3:0] live_addr  = {shift_reg[2:0], din_sync_reg[1]};

    reg [7:0] rd_data;
    always @* begin
        case (live_addr)  // nibble completes with the bit arriving on the eighth edge
            `DAGC_ADDR_POWER:  rd_data = power_reg;
            `DAGC_ADDR_GAIN_A: rd_data = gain_first_reg;
            `DAGC_ADDR_GAIN_B: rd_data = gain_second_reg;
            `DAGC_ADDR_ROUTE:  rd_data = route_reg;
            default:           rd_data = 8'h00;
        endcase
    end

    // =====================================================================
    // serial frame engine
    // select falling wins over a coincident clock edge so a new frame starts clean
    wire take_bit  = selected & sclk_rise & ~sel_fall;
    wire give_bit  = selected & sclk_fall & ~sel_fall;
    wire data_span = (bit_cnt_reg >= `DAGC_DATA_FIRST) && (bit_cnt_reg <= `DAGC_DATA_LAST);
    // a full frame means sixteen rising edges seen; fewer aborts the access
    wire commit    = sel_rise && (bit_cnt_reg == `DAGC_FRAME_BITS) && !frame_read;

    // counter saturates: extra clocks keep shifting and the last sixteen bits count
    always @(posedge core_clk) begin
        if (sys_rst) begin
            bit_cnt_reg <= 5'h00;
        end else if (clk_en) begin
            if (sel_fall)
                bit_cnt_reg <= 5'h00;
            else if (take_bit && bit_cnt_reg != `DAGC_FRAME_BITS)
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
    end

    // bits enter at the bottom, so the first one ends up as bit 15
    always @(posedge core_clk) begin
        if (sys_rst) begin
            shift_reg <= 16'h0000;
        end else if (clk_en) begin
            if (take_bit)
                shift_reg <= {shift_reg[14:0], din_sync_reg[1]};
        end
    end

    // readout byte is latched on the eighth rising edge, then leaves msb first
    always @(posedge core_clk) begin
        if (sys_rst) begin
            out_shift_reg <= 8'h00;
            ser_dout      <= 1'b0;
            ser_dout_oe_n <= 1'b1;
        end else if (clk_en) begin
            ser_dout_oe_n <= ~selected;
            if (sel_fall) begin
                ser_dout <= 1'b0;
            end else if (take_bit && bit_cnt_reg == `DAGC_ADDR_LAST_BIT) begin
                out_shift_reg <= rd_data;
            end else if (give_bit && data_span) begin
                ser_dout      <= out_shift_reg[7];
                out_shift_reg <= {out_shift_reg[6:0], 1'b0};
            end
        end
    end

    // =====================================================================
    // register bank
    // the bank changes only on release of select, so the analog side never
    // sees a half-shifted byte; unmapped addresses fall to the default arm
    always @(posedge core_clk) begin
        if (sys_rst) begin
            power_reg       <= `DAGC_RST_POWER;
            gain_first_reg  <= `DAGC_RST_GAIN;
            gain_second_reg <= `DAGC_RST_GAIN;
            route_reg       <= `DAGC_RST_ROUTE;
        end else if (clk_en && commit) begin
            // reserved frame bits are not decoded at all
            case (frame_addr)
                `DAGC_ADDR_POWER:  power_reg       <= shift_reg[7:0];
                `DAGC_ADDR_GAIN_A: gain_first_reg  <= shift_reg[7:0];
                `DAGC_ADDR_GAIN_B: gain_second_reg <= shift_reg[7:0];
                `DAGC_ADDR_ROUTE:  route_reg       <= shift_reg[7:0];
                default:           power_reg       <= power_reg;
            endcase
        end
    end

    // =====================================================================
    // gain routing and power outputs
    wire        gang        = route_reg[`DAGC_ROUTE_GANG];
    wire        load_a      = route_reg[`DAGC_ROUTE_LOAD_A];
    wire        load_b      = route_reg[`DAGC_ROUTE_LOAD_B];
    wire [6:0]  src_b       = gang ? gain_first_reg[6:0] : gain_second_reg[6:0];
    wire [13:0] src_pair    = {src_b, gain_first_reg[6:0]};
    wire [15:0] stored_pair = {gain_second_reg, gain_first_reg};
    wire [13:0] clamp_pair;
    wire [1:0]  code_bad;

    // codes above 80 would ask for less than 6 dB; clamp to the floor
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            assign clamp_pair[ch*7 +: 7] = (src_pair[ch*7 +: 7] > `DAGC_GAIN_MAX) ?
                                           `DAGC_GAIN_MAX : src_pair[ch*7 +: 7];
            // the stored byte stays readable even when it is out of range
            assign code_bad[ch] = (stored_pair[ch*8 +: 8] > {1'b0, `DAGC_GAIN_MAX});
        end
    endgenerate

    // load bits are levels: while one is set its channel tracks the register
    reg [6:0] chan_a_gain_next;
    reg [6:0] chan_b_gain_next;
    always @* begin
        chan_a_gain_next = chan_a_gain;
        chan_b_gain_next = chan_b_gain;
        if (load_a)
            chan_a_gain_next = clamp_pair[6:0];
        if (load_b)
            chan_b_gain_next = clamp_pair[13:7];
    end

    always @(posedge core_clk) begin
        if (sys_rst) begin
            chan_a_gain       <= `DAGC_RST_CODE;
            chan_b_gain       <= `DAGC_RST_CODE;
            chan_a_off_first  <= 1'b0;
            chan_a_off_second <= 1'b0;
            chan_b_off_first  <= 1'b0;
            chan_b_off_second <= 1'b0;
            gain_code_error   <= 1'b0;
        end else if (clk_en) begin
            chan_a_gain       <= chan_a_gain_next;
            chan_b_gain       <= chan_b_gain_next;
            chan_a_off_first  <= power_reg[`DAGC_POW_A_FIRST];
            chan_a_off_second <= power_reg[`DAGC_POW_A_SECOND];
            chan_b_off_first  <= power_reg[`DAGC_POW_B_FIRST];
            chan_b_off_second <= power_reg[`DAGC_POW_B_SECOND];
            gain_code_error   <= |code_bad;
        end
    end

endmodule

// >>> testbench/dagc_chk.sv
/* port checker for the gain control bank.
   assumes select stays high >= 8 cycles and a serial half period of 4 cycles. */
`timescale 1ns/1ps
module dagc_chk (
    input       core_clk,
    input       sys_rst,
    input       clk_en,
    input       ser_clk,
    input       ser_sel_n,
    input       ser_dout,
    input       ser_dout_oe_n,
    input [6:0] chan_a_gain,
    input [6:0] chan_b_gain,
    input       gain_code_error
);
    // ====================
    // assertions
    wire [13:0] outs = {chan_a_gain, chan_b_gain};
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst || !clk_en);
    a_oe_idle: assert property (ser_sel_n [*5] |-> ser_dout_oe_n)
        else $error("dout driven while idle");
    a_oe_drive: assert property (!ser_sel_n [*5] |-> !ser_dout_oe_n)
        else $error("dout not driven in frame");
    a_reset_gain: assert property ($past(sys_rst) |-> outs == {7'h50, 7'h50})
        else $error("gain reset value");
    a_gain_clamp: assert property (chan_a_gain <= 7'h50 && chan_b_gain <= 7'h50)
        else $error("gain beyond 80");
    a_commit_release: assert property ($changed(outs) |-> ser_sel_n && $past(ser_sel_n, 2))
        else $error("gain moved while selected");
    a_err_release: assert property ($changed(gain_code_error) |-> ser_sel_n)
        else $error("error flag moved while selected");
    a_hold_frame: assert property (!ser_sel_n [*8] |-> $stable(outs))
        else $error("gain unstable in frame");
    a_dout_falling: assert property ($changed(ser_dout) && !ser_dout_oe_n && !$past(ser_dout_oe_n) |-> !$past(ser_clk, 2))
        else $error("dout moved off falling edge");
    // ====================
    // covers
    c_gain: cover property ($changed(chan_a_gain));
    c_err: cover property ($rose(gain_code_error));
    c_read: cover property (!ser_dout_oe_n && ser_dout);
endmodule

// >>> testbench/dagc_spi_master.sv
/* serial master model for the gain control bank link.
   assumes core_clk of 20 ns; serial clock 160 ns, low between frames. */
`timescale 1ns/1ps
module dagc_spi_master (
    input      core_clk,
    output reg ser_clk,
    output reg ser_sel_n,
    output reg ser_din,
    input      ser_dout,
    input      ser_dout_oe_n
);
    // ====================
    // frame driver
    // undriven output line is pulled low by its bias resistor
    wire sdo = ser_dout_oe_n ? 1'b0 : ser_dout;
    initial begin
        ser_clk = 1'b0;
        ser_sel_n = 1'b1;
        ser_din = 1'b0;
    end
    // caller gives direction, zero reserved bits, address, data
    task xfer(input [15:0] w, input integer n, output [7:0] rd);
        integer i;
        rd = 8'h00;
        ser_sel_n <= 1'b0;
        for (i = 0; i < n; i = i + 1) begin
            ser_din <= w[15 - i];
            repeat (4) @(posedge core_clk);
            ser_clk <= 1'b1;
            @(posedge core_clk);
            if (i > 7) rd = {rd[6:0], sdo};
            repeat (3) @(posedge core_clk);
            ser_clk <= 1'b0;
        end
        repeat (5) @(posedge core_clk);
        ser_sel_n <= 1'b1;
        repeat (12) @(posedge core_clk);
    endtask
endmodule

// >>> testbench/dual_amp_gain_control_regs_test.sv
/* self-checking bench for the gain control bank.
   assumes the serial master model and the port checker bound below. */
`timescale 1ns/1ps
module dual_amp_gain_control_regs_test;
    reg         core_clk = 1'b0;
    reg         sys_rst  = 1'b1;
    reg         clk_en   = 1'b1;
    reg  [7:0]  rd_x;
    wire        ser_clk, ser_sel_n, ser_din, ser_dout, oe_n, a1, a2, b1, b2, err;
    wire [6:0]  ga, gb;
    reg  [7:0]  m [0:15];
    reg  [6:0]  ea, eb;
    reg  [31:0] seed = 32'h0000_002c;
    integer     fails = 0, n_checks = 0, cyc = 0, k;
    always #10 core_clk = ~core_clk;
    dagc_regs dagc_regs_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .ser_clk(ser_clk), .ser_sel_n(ser_sel_n), .ser_din(ser_din), .ser_dout(ser_dout),
        .ser_dout_oe_n(oe_n), .chan_a_gain(ga), .chan_b_gain(gb), .chan_a_off_first(a1),
        .chan_a_off_second(a2), .chan_b_off_first(b1), .chan_b_off_second(b2),
        .gain_code_error(err));
    dagc_spi_master dagc_spi_master_i (.core_clk(core_clk), .ser_clk(ser_clk),
        .ser_sel_n(ser_sel_n), .ser_din(ser_din), .ser_dout(ser_dout), .ser_dout_oe_n(oe_n));
    // ====================
    // helpers
    function [31:0] xs(input [31:0] s);
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task model_init;
        integer j;
        for (j = 0; j < 16; j = j + 1) m[j] = 8'h00;
        m[3] = 8'h50;
        m[4] = 8'h50;
        m[5] = 8'h03;
        ea = 7'h50;
        eb = 7'h50;
    endtask
    function [6:0] cl(input [7:0] v);
        cl = (v > 8'h50) ? 7'h50 : v[6:0];
    endfunction
    task cmp(input string nm, input [7:0] e, input [7:0] s);
        n_checks = n_checks + 1;
        if (s !== e) begin
            fails = fails + 1;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task check_all;
        reg [7:0] rd;
        integer a;
        for (a = 2; a < 8; a = a + 1) begin
            dagc_spi_master_i.xfer({4'h8, a[3:0], 8'h5a}, 16, rd);
            cmp("reg", m[a], rd);
        end
        cmp("gain_a", {1'b0, ea}, {1'b0, ga});
        cmp("gain_b", {1'b0, eb}, {1'b0, gb});
        cmp("off", {4'h0, m[2][5], m[2][3], m[2][4], m[2][2]}, {4'h0, a1, a2, b1, b2});
        cmp("err", {7'h00, (m[3] > 8'h50) || (m[4] > 8'h50)}, {7'h00, err});
    endtask
    // short frames and unmapped addresses leave the model untouched
    task wr(input [3:0] a, input [7:0] d, input integer n);
        reg [7:0] rd;
        dagc_spi_master_i.xfer({4'h0, a, d}, n, rd);
        if (n == 16 && a > 1 && a < 6) m[a] = d;
        if (m[5][1]) ea = cl(m[3]);
        if (m[5][0]) eb = cl(m[5][2] ? m[3] : m[4]);
        check_all;
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            print_verdict;
        end
    end
    // ====================
    // scenarios
    initial begin
        model_init;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge core_clk);
        check_all;
        wr(4'h3, 8'h11, 15);
        wr(4'h5, 8'h00, 16);
        wr(4'h3, 8'h20, 16);
        wr(4'h5, 8'h02, 16);
        wr(4'h5, 8'h07, 16);
        wr(4'h4, 8'h7f, 16);
        wr(4'h5, 8'h01, 16);
        wr(4'h6, 8'h33, 16);
        for (k = 0; k < 12; k = k + 1) begin
            seed = xs(seed);
            wr(seed[9:8] + 4'h2, seed[7:0] & (seed[9:8] == 2'd0 ? 8'h3c :
               seed[9:8] == 2'd3 ? 8'h07 : 8'h7f), 16);
        end
        // a frame sent while the block is frozen must leave no trace
        clk_en <= 1'b0;
        dagc_spi_master_i.xfer({4'h0, 4'h3, 8'h44}, 16, rd_x);
        clk_en <= 1'b1;
        check_all;
        // second reset in mid-run brings the bank back to its defaults
        sys_rst <= 1'b1;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        model_init;
        repeat (4) @(posedge core_clk);
        check_all;
        print_verdict;
    end
endmodule
bind dagc_regs dagc_chk dagc_chk_i (.core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .ser_clk(ser_clk),
    .ser_sel_n(ser_sel_n), .ser_dout(ser_dout), .ser_dout_oe_n(ser_dout_oe_n),
    .chan_a_gain(chan_a_gain), .chan_b_gain(chan_b_gain), .gain_code_error(gain_code_error));
